// >>> byte_fifo.sv
// Byte FIFO that buffers the received stream ahead of the parser
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    byte_if.src               out
);
    localparam int AW = $clog2(DEPTH);

    logic [AW:0]  wr_ptr_r;
    logic [AW:0]  rd_ptr_r;
    logic [W-1:0] mem_r [DEPTH];
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW])
                && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready  = !full;
    assign out.valid = !empty;
    assign out.data  = mem_r[rd_ptr_r[AW-1:0]];
    assign push = in_valid && !full;
    assign pop  = out.ready && !empty;

    // Storage needs no reset; the pointers gate every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> byte_if.sv
// Valid/ready byte channel between the buffer and the parser
`timescale 1ns/1ps
`default_nettype none
interface byte_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> parser_pkg.sv
// Constants, commands and states of the serial input parser
package parser_pkg;
    localparam int          BYTE_W     = 8;
    localparam int          NUM_W      = 16;
    localparam int          FIFO_DEPTH = 8;
    localparam int          WAIT_MAX   = 6;
    localparam logic [2:0]  WAIT_MAX_C = 3'h6;
    localparam logic [7:0]  SP_MAX     = 8'h7E;
    localparam logic [2:0]  DIGITS_MAX = 3'h5;
    localparam logic [7:0]  DIGIT_LO   = 8'h30;
    localparam logic [7:0]  DIGIT_HI   = 8'h39;
    localparam logic [7:0]  FILL_BYTE  = 8'h00;
    localparam logic [7:0]  SP_BASE    = 8'h00;
    localparam logic [15:0] NUM_RADIX  = 16'h000A;
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;

    typedef enum logic [2:0] {
        OP_NUM   = 3'b000,
        OP_STR   = 3'b001,
        OP_WAIT  = 3'b010,
        OP_AWAIT = 3'b011,
        OP_SKIP  = 3'b100,
        OP_SP    = 3'b101
    } op_t;

    typedef enum logic [3:0] {
        S_IDLE     = 4'b0000,
        S_NUM      = 4'b0001,
        S_STR      = 4'b0010,
        S_ZFILL    = 4'b0011,
        S_WAIT     = 4'b0100,
        S_AW_FETCH = 4'b0101,
        S_AW_CMP   = 4'b0110,
        S_SKIP     = 4'b0111,
        S_SP       = 4'b1000,
        S_FIN      = 4'b1001
    } st_t;
endpackage

// >>> serial_input_parser.sv
// Serial input parser: runs input actions on a received byte stream
`timescale 1ns/1ps
`default_nettype none
// Function
// - Result keeps low 8 or 16 bits
// - Unlimited number ends at first non-digit
// - Digit limit stops conversion early
// - String stored up to length or terminator
// - Early end zero-fills remaining elements
// - Terminator byte is never stored
// - Literal wait pattern holds up to six bytes
// - Exact case-sensitive match, other input ignored
// - Wait holds until whole pattern seen
// - Array wait uses length or zero end
// - Skip discards exactly the given count
// - Scratch-pad capture, at most 126, from zero
// - Actions run in order on the stream
// - Number waits for first accepted digit
module serial_input_parser
    import parser_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Received byte stream
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [7:0]  rx_data,
    // Action command
    input  wire logic        act_valid,
    output logic             act_ready,
    input  wire op_t         act_op,
    input  wire logic [7:0]  act_len,
    input  wire logic [7:0]  act_base,
    input  wire logic        act_term_en,
    input  wire logic [7:0]  act_term,
    input  wire logic [2:0]  act_digits,
    input  wire logic        act_word,
    input  wire logic [47:0] act_pat,
    input  wire logic [2:0]  act_pat_len,
    output logic             act_done,
    // Numeric result
    output logic             num_valid,
    output logic [15:0]      num_data,
    // Storage write
    output logic             mem_we,
    output logic             mem_sp,
    output logic [7:0]       mem_addr,
    output logic [7:0]       mem_wdata,
    // Storage read
    output logic [7:0]       mem_rd_addr,
    input  wire logic [7:0]  mem_rd_data
);
    byte_if bus ();

    st_t         st_r;
    op_t         op_r;
    logic [7:0]  len_r;
    logic [7:0]  base_r;
    logic        term_en_r;
    logic [7:0]  term_r;
    logic [2:0]  dlim_r;
    logic        word_r;
    logic [47:0] pat_r;
    logic [2:0]  plen_r;
    logic [7:0]  idx_r;
    logic [7:0]  rd_addr_r;
    logic [15:0] acc_r;
    logic [2:0]  ndig_r;
    logic        started_r;
    logic [47:0] hist_r;
    logic [2:0]  hcnt_r;
    logic        we_r;
    logic        sp_r;
    logic [7:0]  addr_r;
    logic [7:0]  wdata_r;
    logic [15:0] num_r;

    logic        take;
    logic [7:0]  byt;
    logic        is_digit;
    logic [15:0] acc_nxt;
    logic        lim_hit;
    logic [7:0]  idx_inc;
    logic        is_term;
    logic        aw_end;
    logic [47:0] hist_nxt;
    logic [5:0]  byte_ok;
    logic        wait_match;

    default clocking cb_chk @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // The buffer lets the sender run ahead while an action is busy
    byte_fifo #(
        .W     (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .in_valid (rx_valid),
        .in_ready (rx_ready),
        .in_data  (rx_data),
        .out      (bus)
    );

    assign byt      = bus.data;
    assign take     = bus.valid && bus.ready;
    assign is_digit = (byt >= DIGIT_LO) && (byt <= DIGIT_HI);
    assign acc_nxt  = 16'(acc_r * NUM_RADIX)
                    + {12'h000, 4'(byt - DIGIT_LO)};
    assign lim_hit  = (dlim_r != 3'h0)
                   && (3'(ndig_r + 3'h1) == dlim_r);
    assign idx_inc  = idx_r + 8'h01;
    assign is_term  = term_en_r && (byt == term_r);
    assign aw_end   = (len_r == 8'h00) ? (mem_rd_data == FILL_BYTE)
                                       : (idx_r == len_r);
    assign hist_nxt = {hist_r[39:0], byt};

    // Exact byte compare of the newest bytes against the pattern
    genvar gi;
    generate
        for (gi = 0; gi < WAIT_MAX; gi++) begin : g_cmp
            assign byte_ok[gi] = (3'(gi) >= plen_r)
                || (hist_nxt[8*gi +: 8] == pat_r[8*gi +: 8]);
        end
    endgenerate
    assign wait_match = (&byte_ok) && (3'(hcnt_r + 3'h1) >= plen_r);

    always_comb begin
        unique case (st_r)
            S_NUM, S_STR, S_WAIT, S_SKIP, S_SP: bus.ready = 1'b1;
            S_AW_CMP: bus.ready = !aw_end;
            default:  bus.ready = 1'b0;
        endcase
    end

    assign act_ready   = (st_r == S_IDLE);
    assign act_done    = (st_r == S_FIN);
    assign num_valid   = (st_r == S_FIN) && (op_r == OP_NUM);
    assign num_data    = num_r;
    assign mem_we      = we_r;
    assign mem_sp      = sp_r;
    assign mem_addr    = addr_r;
    assign mem_wdata   = wdata_r;
    assign mem_rd_addr = rd_addr_r;

    function automatic logic [15:0] fit(input logic [15:0] v,
                                        input logic        w);
        fit = w ? v : {8'h00, v[7:0]};
    endfunction

    // Sequencer: one action at a time, each from the next byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r      <= S_IDLE;
            op_r      <= OP_NUM;
            len_r     <= RST_BYTE;
            base_r    <= RST_BYTE;
            term_en_r <= 1'b0;
            term_r    <= RST_BYTE;
            dlim_r    <= 3'h0;
            word_r    <= 1'b0;
            pat_r     <= '0;
            plen_r    <= 3'h0;
            idx_r     <= RST_BYTE;
            rd_addr_r <= RST_BYTE;
        end else begin
            unique case (st_r)
                S_IDLE: begin
                    if (act_valid) begin
                        op_r      <= act_op;
                        base_r    <= act_base;
                        term_en_r <= act_term_en;
                        term_r    <= act_term;
                        word_r    <= act_word;
                        pat_r     <= act_pat;
                        idx_r     <= RST_BYTE;
                        rd_addr_r <= act_base;
                        dlim_r    <= (act_digits > DIGITS_MAX)
                                   ? DIGITS_MAX : act_digits;
                        plen_r    <= (act_pat_len > WAIT_MAX_C)
                                   ? WAIT_MAX_C : act_pat_len;
                        len_r     <= (act_op == OP_SP && act_len > SP_MAX)
                                   ? SP_MAX : act_len;
                        unique case (act_op)
                            OP_NUM:   st_r <= S_NUM;
                            OP_STR:   st_r <= (act_len == 8'h00)
                                            ? S_FIN : S_STR;
                            OP_WAIT:  st_r <= (act_pat_len == 3'h0)
                                            ? S_FIN : S_WAIT;
                            OP_AWAIT: st_r <= S_AW_FETCH;
                            OP_SKIP:  st_r <= (act_len == 8'h00)
                                            ? S_FIN : S_SKIP;
                            OP_SP:    st_r <= (act_len == 8'h00)
                                            ? S_FIN : S_SP;
                            default:  st_r <= S_FIN;
                        endcase
                    end
                end
                S_NUM: begin
                    if (take && is_digit && lim_hit) begin
                        st_r <= S_FIN;
                    end else if (take && !is_digit && started_r) begin
                        st_r <= S_FIN;
                    end
                end
                S_STR: begin
                    if (take && is_term) begin
                        st_r <= S_ZFILL;
                    end else if (take) begin
                        idx_r <= idx_inc;
                        st_r  <= (idx_inc == len_r) ? S_FIN : S_STR;
                    end
                end
                S_ZFILL: begin
                    idx_r <= idx_inc;
                    st_r  <= (idx_inc == len_r) ? S_FIN : S_ZFILL;
                end
                S_WAIT: begin
                    if (take && wait_match) begin
                        st_r <= S_FIN;
                    end
                end
                S_AW_FETCH: begin
                    st_r <= S_AW_CMP;
                end
                S_AW_CMP: begin
                    if (aw_end) begin
                        st_r <= S_FIN;
                    end else if (take) begin
                        // Restart on a miss; simple, but may miss overlaps
                        idx_r     <= (byt == mem_rd_data) ? idx_inc
                                                          : RST_BYTE;
                        rd_addr_r <= (byt == mem_rd_data)
                                   ? base_r + idx_inc : base_r;
                        st_r      <= S_AW_FETCH;
                    end
                end
                S_SKIP, S_SP: begin
                    if (take) begin
                        idx_r <= idx_inc;
                        if (idx_inc == len_r) begin
                            st_r <= S_FIN;
                        end
                    end
                end
                S_FIN: begin
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Decimal accumulator; wraps silently past 16 bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r     <= RST_WORD;
            ndig_r    <= 3'h0;
            started_r <= 1'b0;
            num_r     <= RST_WORD;
        end else if (st_r == S_IDLE) begin
            acc_r     <= RST_WORD;
            ndig_r    <= 3'h0;
            started_r <= 1'b0;
        end else if (st_r == S_NUM && take) begin
            if (is_digit) begin
                acc_r     <= acc_nxt;
                ndig_r    <= 3'(ndig_r + 3'h1);
                started_r <= 1'b1;
                if (lim_hit) begin
                    num_r <= fit(acc_nxt, word_r);
                end
            end else if (started_r) begin
                num_r <= fit(acc_r, word_r);
            end
        end
    end

    // History of the newest bytes for the literal wait
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hist_r <= '0;
            hcnt_r <= 3'h0;
        end else if (st_r == S_IDLE) begin
            hist_r <= '0;
            hcnt_r <= 3'h0;
        end else if (st_r == S_WAIT && take) begin
            hist_r <= hist_nxt;
            hcnt_r <= (hcnt_r == WAIT_MAX_C) ? hcnt_r : 3'(hcnt_r + 3'h1);
        end
    end

    // Storage write port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            we_r    <= 1'b0;
            sp_r    <= 1'b0;
            addr_r  <= RST_BYTE;
            wdata_r <= RST_BYTE;
        end else begin
            we_r <= 1'b0;
            if (st_r == S_STR && take && !is_term) begin
                we_r    <= 1'b1;
                sp_r    <= 1'b0;
                addr_r  <= base_r + idx_r;
                wdata_r <= byt;
            end else if (st_r == S_ZFILL) begin
                we_r    <= 1'b1;
                sp_r    <= 1'b0;
                addr_r  <= base_r + idx_r;
                wdata_r <= FILL_BYTE;
            end else if (st_r == S_SP && take) begin
                we_r    <= 1'b1;
                sp_r    <= 1'b1;
                addr_r  <= SP_BASE + idx_r;
                wdata_r <= byt;
            end
        end
    end

    a_byte_trunc: assert property (
        num_valid && !word_r |-> num_data[15:8] == 8'h00)
        else $error("byte result not truncated");
    a_nondigit_end: assert property (
        st_r == S_NUM && take && started_r && !is_digit
        |=> num_valid ##1 st_r == S_IDLE)
        else $error("number did not end on non-digit");
    a_two_digit: assert property (
        num_valid && dlim_r == 3'h2 |-> num_data <= 16'h0063)
        else $error("two-digit result above 99");
    a_term_unstored: assert property (
        st_r == S_STR && take && is_term |=> !mem_we)
        else $error("terminator was stored");
    a_zero_fill: assert property (
        st_r == S_ZFILL |=> mem_we && mem_wdata == FILL_BYTE
            && mem_addr == 8'($past(base_r) + $past(idx_r)))
        else $error("fill byte wrong");
    a_wait_hold: assert property (
        st_r == S_WAIT && !take |=> st_r == S_WAIT)
        else $error("wait left without a byte");
    a_skip_silent: assert property (
        st_r == S_SKIP && take |=> !mem_we && !num_valid)
        else $error("skip stored data");
    a_sp_range: assert property (
        mem_we && mem_sp |-> mem_addr < SP_MAX)
        else $error("scratch-pad address out of range");
    a_lead_discard: assert property (
        st_r == S_NUM && !started_r && take && !is_digit
        |=> st_r == S_NUM && !num_valid)
        else $error("leading byte not discarded");
    a_str_bound: assert property (
        mem_we && !mem_sp |-> 8'(mem_addr - base_r) < len_r)
        else $error("string write beyond length");
    a_done_order: assert property (
        act_done |=> act_ready && !act_done)
        else $error("action overlap");

    c_num_done: cover property (num_valid && word_r);
    c_str_fill: cover property (st_r == S_ZFILL ##1 st_r == S_FIN);
    c_wait_hit: cover property (st_r == S_WAIT && take && wait_match
        && plen_r == WAIT_MAX_C);
    c_await_hit: cover property (st_r == S_AW_CMP && aw_end
        && idx_r != 8'h00);
endmodule
`default_nettype wire

// >>> serial_input_parser_tb_top.sv
// Self-checking testbench of the serial input parser
`timescale 1ns/1ps
`default_nettype none
module serial_input_parser_tb_top
    import parser_pkg::*;
;
    logic        clk, reset_n, rx_valid, rx_ready, act_valid, act_ready;
    logic        act_term_en, act_word, act_done, num_valid, slow;
    logic        mem_we, mem_sp;
    logic [7:0]  rx_data, act_len, act_base, act_term, mem_addr, mem_wdata;
    logic [7:0]  mem_rd_addr, mem_rd_data;
    logic [2:0]  act_digits, act_pat_len;
    logic [47:0] act_pat;
    logic [15:0] num_data, got_num;
    op_t         act_op;
    logic [7:0]  vmem[256];
    logic [7:0]  spmem[128];
    logic        got_nv;
    int          n_fail, total_checks;

    serial_input_parser i_dut (.clk(clk), .reset_n(reset_n),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .act_valid(act_valid), .act_ready(act_ready), .act_op(act_op),
        .act_len(act_len), .act_base(act_base), .act_term_en(act_term_en),
        .act_term(act_term), .act_digits(act_digits), .act_word(act_word),
        .act_pat(act_pat), .act_pat_len(act_pat_len), .act_done(act_done),
        .num_valid(num_valid), .num_data(num_data), .mem_we(mem_we),
        .mem_sp(mem_sp), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));

    serial_sender_model i_snd (.clk(clk), .reset_n(reset_n),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .slow(slow));

    always #5 clk = ~clk;

    // Storage: writes land on the edge, reads answer one cycle later
    always @(posedge clk) begin
        if (mem_we === 1'b1 && mem_sp === 1'b1) spmem[mem_addr[6:0]] <= mem_wdata;
        if (mem_we === 1'b1 && mem_sp === 1'b0) vmem[mem_addr] <= mem_wdata;
        mem_rd_data <= vmem[mem_rd_addr];
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input string s);
        foreach (s[i]) i_snd.push(s[i]);
    endtask

    // Offer one command, held until the parser takes it
    task automatic issue(input op_t op, input logic [7:0] len, base,
                         input logic te, input logic [7:0] term,
                         input logic [2:0] dig, input logic wd,
                         input logic [47:0] pat, input logic [2:0] pl);
        int k;
        act_valid = 1'b1;
        act_op = op; act_len = len; act_base = base; act_term_en = te;
        act_term = term; act_digits = dig; act_word = wd;
        act_pat = pat; act_pat_len = pl;
        for (k = 0; k < 50 && act_ready !== 1'b1; k++) @(negedge clk);
        if (k == 50) begin
            n_fail++;
            $display("[ERR] %0t command never taken", $time);
            stop_test();
        end
        @(negedge clk);
        act_valid = 1'b0;
    endtask

    task automatic wait_done;
        int k;
        for (k = 0; k < 400 && act_done !== 1'b1; k++) @(negedge clk);
        if (k == 400) begin
            n_fail++;
            $display("[ERR] %0t action never finished", $time);
            stop_test();
        end
        got_num = num_data;
        got_nv  = num_valid;
        @(negedge clk);
    endtask

    task automatic num(input logic [2:0] dig, input logic wd,
                       input logic [15:0] exp);
        issue(OP_NUM, 8'h00, 8'h00, 1'b0, 8'h00, dig, wd, 48'h0, 3'h0);
        wait_done();
        chk(got_nv, 1'b1);
        chk(got_num, exp);
    endtask

    task automatic t_number;
        send("ab123456x300;987;");
        num(3'h0, 1'b1, 16'hE240);
        num(3'h0, 1'b0, 16'h002C);
        num(3'h2, 1'b1, 16'h0062);
        num(3'h0, 1'b1, 16'h0007);
    endtask

    task automatic t_string;
        for (int i = 10; i < 15; i++) vmem[i] = 8'hAA;
        slow = 1'b1;
        send("ab*wxy");
        issue(OP_STR, 8'h04, 8'h0A, 1'b1, "*", 3'h0, 1'b0, 48'h0, 3'h0);
        wait_done();
        chk(vmem[10], "a");
        chk(vmem[11], "b");
        chk(vmem[12], 8'h00);
        chk(vmem[13], 8'h00);
        chk(vmem[14], 8'hAA);
        issue(OP_STR, 8'h03, 8'h28, 1'b0, 8'h00, 3'h0, 1'b0, 48'h0, 3'h0);
        wait_done();
        chk({vmem[41], vmem[42]}, "xy");
        chk(vmem[40], "w");
        slow = 1'b0;
    endtask

    task automatic t_wait;
        logic seen;
        seen = 1'b0;
        send("sesameSESAM");
        issue(OP_WAIT, 8'h00, 8'h00, 1'b0, 8'h00, 3'h0, 1'b0, "SESAME",
              3'h6);
        repeat (40) begin
            @(negedge clk);
            if (act_done !== 1'b0) seen = 1'b1;
        end
        chk(seen, 1'b0);
        send("E5;");
        wait_done();
        num(3'h0, 1'b1, 16'h0005);
    endtask

    task automatic t_await;
        vmem[20] = "o"; vmem[21] = "k"; vmem[22] = 8'h00;
        vmem[30] = "a"; vmem[31] = "b"; vmem[32] = "c";
        send("oxokab7;");
        issue(OP_AWAIT, 8'h00, 8'h14, 1'b0, 8'h00, 3'h0, 1'b0, 48'h0, 3'h0);
        wait_done();
        issue(OP_AWAIT, 8'h02, 8'h1E, 1'b0, 8'h00, 3'h0, 1'b0, 48'h0, 3'h0);
        wait_done();
        num(3'h0, 1'b1, 16'h0007);
    endtask

    task automatic t_skip_sp;
        send("12345;PQR");
        issue(OP_SKIP, 8'h03, 8'h00, 1'b0, 8'h00, 3'h0, 1'b0, 48'h0, 3'h0);
        wait_done();
        num(3'h0, 1'b1, 16'h002D);
        issue(OP_SP, 8'h03, 8'h00, 1'b0, 8'h00, 3'h0, 1'b0, 48'h0, 3'h0);
        wait_done();
        chk({spmem[0], spmem[1]}, "PQ");
        chk(spmem[2], "R");
    endtask

    // Buffer fills while no action runs, then drains in one skip
    task automatic t_fifo;
        send("1234567894;");
        repeat (20) @(negedge clk);
        chk(rx_ready, 1'b0);
        chk(rx_valid, 1'b1);
        issue(OP_SKIP, 8'h09, 8'h00, 1'b0, 8'h00, 3'h0, 1'b0, 48'h0, 3'h0);
        wait_done();
        num(3'h0, 1'b0, 16'h0004);
    endtask

    initial begin
        clk = 1'b0; reset_n = 1'b0; slow = 1'b0; act_valid = 1'b0;
        act_op = OP_NUM; act_len = 8'h00; act_base = 8'h00;
        act_term_en = 1'b0; act_term = 8'h00; act_digits = 3'h0;
        act_word = 1'b0; act_pat = 48'h0; act_pat_len = 3'h0;
        mem_rd_data = 8'h00;
        n_fail = 0; total_checks = 0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        chk(act_ready, 1'b1);
        t_number();
        t_string();
        t_wait();
        t_await();
        t_skip_sp();
        t_fifo();
        stop_test();
    end
endmodule
`default_nettype wire

// >>> serial_sender_model.sv
// Behavioural model of the external sender that feeds bytes to the parser
`timescale 1ns/1ps
`default_nettype none
module serial_sender_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Byte stream towards the parser
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic [7:0]      rx_data,
    // Pacing: one idle cycle after each byte when set
    input  wire logic       slow
);
    logic [7:0] q[$];
    logic       took;

    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        took     = 1'b0;
    end

    // A byte counts as delivered only where valid meets ready
    always @(posedge clk) begin
        took <= rx_valid & rx_ready;
    end

    // One byte at a time, held until taken; idle data toggles so that
    // a parser sampling a released line cannot see a stale byte
    always @(negedge clk) begin
        if (!reset_n) begin
            rx_valid <= 1'b0;
        end else begin
            if (took) begin
                void'(q.pop_front());
            end
            if (rx_valid && !took) begin
                rx_valid <= 1'b1;
            end else if (q.size() > 0 && !(slow && took)) begin
                rx_valid <= 1'b1;
                rx_data  <= q[0];
            end else begin
                rx_valid <= 1'b0;
                rx_data  <= ~rx_data;
            end
        end
    end
endmodule
`default_nettype wire
